//--- bench/port_master.sv
// Purpose: Behavioural external controller on the parallel port.
// Assumes: Strobes and bus data change at the falling clock edge.
// Notes: Waits on the flags under a bounded count; ok low means gave up.
`timescale 1ns/1ps
`default_nettype none
module port_master
  import fifo_port_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Device side of the port
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic dev_data_oe_i,
  input wire logic rx_flag_n_i,
  input wire logic tx_flag_n_i,
  // Strobes and resolved bus level
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [DATA_W-1:0] bus_level_o
);
  logic drive;
  logic [DATA_W-1:0] drive_data;
  logic [DATA_W-1:0] last;

  // Floating bus shows the inverse of its last level, never a stale copy
  assign bus_level_o = dev_data_oe_i ? dev_data_i : (drive ? drive_data : ~last);

  always @(posedge clock_i) begin
    last <= bus_level_o;
  end

  initial begin
    read_strobe_n_o = 1'h1;
    write_strobe_n_o = 1'h1;
    drive = 1'h0;
    drive_data = 8'h00;
    last = 8'h00;
  end

  // ==========================================================
  // Transfers
  task automatic wait_low(input logic use_tx, output logic ok);
    int n;
    ok = 1'h0;
    for (n = 0; n < 40 && !ok; n++) begin
      @(negedge clock_i);
      ok = use_tx ? (tx_flag_n_i === 1'h0) : (rx_flag_n_i === 1'h0);
    end
  endtask

  task automatic do_read(output logic [DATA_W-1:0] data, output logic flag_after,
                         output logic ok);
    wait_low(1'h0, ok);
    if (ok) begin
      drive = 1'h0;
      read_strobe_n_o = 1'h0;
      repeat (2) @(negedge clock_i);
      data = bus_level_o;
      read_strobe_n_o = 1'h1;
      repeat (2) @(negedge clock_i);
      flag_after = rx_flag_n_i;
      @(negedge clock_i);
    end
  endtask

  task automatic do_write(input logic [DATA_W-1:0] data, output logic ok);
    wait_low(1'h1, ok);
    if (ok) begin
      drive_data = data;
      drive = 1'h1;
      write_strobe_n_o = 1'h0;
      @(negedge clock_i);
      write_strobe_n_o = 1'h1;
      drive = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/test_async_byte_fifo_port.sv
// Purpose: Self-checking bench for the asynchronous byte FIFO port.
// Assumes: Inputs change at the falling edge; flags have pull-ups.
// Notes: USB sides and the wake strobe are driven directly; the rest of the port by port_master.
`timescale 1ns/1ps
`default_nettype none
module test_async_byte_fifo_port;
  import fifo_port_pkg::*;
  logic clock_i, reset_n_i, mode_enable, wake_enable, configured_n, wake_n;
  logic rx_valid, tx_ready, rd_n, wr_n, bus_oe, rx_flag, rx_flag_oe, tx_flag, tx_flag_oe;
  logic rx_ready, tx_valid, send_now, resume;
  logic [DATA_W-1:0] rx_data, bus_level, dut_bus, tx_data;
  logic rx_flag_n, tx_flag_n;
  int miscompares, cmp_count, cycles;

  // Undriven flags float high through their pull-ups
  assign rx_flag_n = rx_flag_oe ? rx_flag : 1'h1;
  assign tx_flag_n = tx_flag_oe ? tx_flag : 1'h1;

  async_byte_fifo_port #(.DEPTH(FIFO_DEPTH)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .mode_enable_i(mode_enable),
    .remote_wakeup_enable_i(wake_enable), .usb_configured_n_i(configured_n),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .send_now_wakeup_n_i(wake_n),
    .chan_data_bus_i(bus_level), .chan_data_bus_o(dut_bus), .chan_data_bus_oe_o(bus_oe),
    .rx_data_available_n_o(rx_flag), .rx_data_available_n_oe_o(rx_flag_oe),
    .tx_space_available_n_o(tx_flag), .tx_space_available_n_oe_o(tx_flag_oe),
    .usb_rx_valid_i(rx_valid), .usb_rx_ready_o(rx_ready), .usb_rx_data_i(rx_data),
    .usb_tx_valid_o(tx_valid), .usb_tx_ready_i(tx_ready), .usb_tx_data_o(tx_data),
    .send_now_o(send_now), .resume_request_o(resume));

  port_master host (
    .clock_i(clock_i), .dev_data_i(dut_bus), .dev_data_oe_i(bus_oe),
    .rx_flag_n_i(rx_flag_n), .tx_flag_n_i(tx_flag_n), .read_strobe_n_o(rd_n),
    .write_strobe_n_o(wr_n), .bus_level_o(bus_level));

  initial begin
    clock_i = 1'h0;
  end

  always #12.5 clock_i = ~clock_i;

  // ==========================================================
  // Reporting
  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================
  // Scenarios
  task automatic test_reset;
    repeat (6) @(negedge clock_i);
    check("rx_flag_oe_in_reset", rx_flag_oe, 1'h0);
    check("tx_flag_oe_in_reset", tx_flag_oe, 1'h0);
    check("bus_oe_in_reset", bus_oe, 1'h0);
    reset_n_i = 1'h1;
    repeat (2) @(negedge clock_i);
    check("rx_flag_empty", rx_flag_n, 1'h1);
    check("tx_flag_room", tx_flag_n, 1'h0);
    $display("test_reset done");
  endtask

  task automatic test_receive;
    logic [DATA_W-1:0] got;
    logic flag_after, ok;
    int i;
    for (i = 0; i < FIFO_DEPTH; i++) begin
      check("rx_ready_room", rx_ready, 1'h1);
      rx_valid = 1'h1;
      rx_data = 8'hA0 + 8'(i);
      @(negedge clock_i);
    end
    rx_valid = 1'h0;
    check("rx_ready_full", rx_ready, 1'h0);
    check("rx_flag_waiting", rx_flag_n, 1'h0);
    for (i = 0; i < FIFO_DEPTH; i++) begin
      host.do_read(got, flag_after, ok);
      check("read_ok", ok, 1'h1);
      check("read_byte", got, 8'hA0 + 8'(i));
      check("rx_flag_after_read", flag_after, 1'h1);
      check("bus_released", bus_oe, 1'h0);
    end
    repeat (2) @(negedge clock_i);
    check("rx_flag_drained", rx_flag_n, 1'h1);
    $display("test_receive done");
  endtask

  task automatic test_transmit;
    logic ok;
    int i;
    tx_ready = 1'h0;
    for (i = 0; i < FIFO_DEPTH; i++) begin
      host.do_write(8'h5A ^ 8'(i), ok);
      check("write_ok", ok, 1'h1);
    end
    @(negedge clock_i);
    check("tx_flag_full", tx_flag_n, 1'h1);
    host.do_write(8'hFF, ok);
    check("write_held_off", ok, 1'h0);
    tx_ready = 1'h1;
    for (i = 0; i < FIFO_DEPTH; i++) begin
      check("tx_valid", tx_valid, 1'h1);
      check("tx_byte", tx_data, 8'h5A ^ 8'(i));
      @(negedge clock_i);
    end
    tx_ready = 1'h0;
    check("tx_empty", tx_valid, 1'h0);
    @(negedge clock_i);
    check("tx_flag_room_again", tx_flag_n, 1'h0);
    $display("test_transmit done");
  endtask

  task automatic test_wake;
    // Bits: configured_n, wakeup enable, flush expected, resume expected
    logic [3:0] cases [4] = '{4'b0110, 4'b1101, 4'b1000, 4'b0010};
    int i;
    for (i = 0; i < 4; i++) begin
      configured_n = cases[i][3];
      wake_enable = cases[i][2];
      wake_n = 1'h0;
      // Pulse shows from the rising edge that samples the fall, for one cycle
      @(negedge clock_i);
      check("send_now", send_now, cases[i][1]);
      check("resume", resume, cases[i][0]);
      @(negedge clock_i);
      check("pulse_one_cycle", {send_now, resume}, 2'b00);
      wake_n = 1'h1;
      @(negedge clock_i);
      check("no_pulse_on_rise", {send_now, resume}, 2'b00);
    end
    configured_n = 1'h0;
    $display("test_wake done");
  endtask

  task automatic test_mode_off;
    mode_enable = 1'h0;
    repeat (2) @(negedge clock_i);
    check("rx_flag_oe_off", rx_flag_oe, 1'h0);
    check("tx_flag_oe_off", tx_flag_oe, 1'h0);
    wake_n = 1'h0;
    repeat (2) @(negedge clock_i);
    check("wake_ignored", {send_now, resume}, 2'b00);
    wake_n = 1'h1;
    mode_enable = 1'h1;
    repeat (2) @(negedge clock_i);
    check("tx_flag_oe_on", tx_flag_oe, 1'h1);
    $display("test_mode_off done");
  endtask

  initial begin
    reset_n_i = 1'h0;
    mode_enable = 1'h1;
    wake_enable = 1'h0;
    configured_n = 1'h0;
    wake_n = 1'h1;
    rx_valid = 1'h0;
    rx_data = 8'h00;
    tx_ready = 1'h0;
    test_reset();
    test_receive();
    test_transmit();
    test_wake();
    test_mode_off();
    summarize();
  end
endmodule
`default_nettype wire

//--- core/async_byte_fifo_port.sv
// Purpose: Asynchronous byte FIFO port of one channel, device end.
// Assumes: Strobes and data are synchronous to clock_i.
// Notes: Receive and transmit each pass through a 4-word FIFO.
`timescale 1ns/1ps
`default_nettype none
module async_byte_fifo_port
  import fifo_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Configuration straps
  input wire logic mode_enable_i,
  input wire logic remote_wakeup_enable_i,
  input wire logic usb_configured_n_i,
  // Parallel port strobes
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic send_now_wakeup_n_i,
  // Parallel port data bus, split in three
  input wire logic [DATA_W-1:0] chan_data_bus_i,
  output logic [DATA_W-1:0] chan_data_bus_o,
  output logic chan_data_bus_oe_o,
  // Parallel port flags, each with its enable
  output logic rx_data_available_n_o,
  output logic rx_data_available_n_oe_o,
  output logic tx_space_available_n_o,
  output logic tx_space_available_n_oe_o,
  // USB side, received bytes in
  input wire logic usb_rx_valid_i,
  output logic usb_rx_ready_o,
  input wire logic [DATA_W-1:0] usb_rx_data_i,
  // USB side, transmit bytes out
  output logic usb_tx_valid_o,
  input wire logic usb_tx_ready_i,
  output logic [DATA_W-1:0] usb_tx_data_o,
  // USB side, wake strobe actions
  output logic send_now_o,
  output logic resume_request_o
);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("async_byte_fifo_port DEPTH must be a power of two, at least 2");
  end

  // ==========================================================
  // Strobe edge detection
  logic [STROBE_COUNT-1:0] strobe_level;
  logic [STROBE_COUNT-1:0] strobe_fell;
  logic [STROBE_COUNT-1:0] strobe_rose;

  assign strobe_level = {send_now_wakeup_n_i, write_strobe_n_i, read_strobe_n_i};

  for (genvar i = 0; i < STROBE_COUNT; i++) begin : g_strobe
    strobe_edge u_edge (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .strobe_n_i(strobe_level[i]),
      .fell_o(strobe_fell[i]),
      .rose_o(strobe_rose[i])
    );
  end

  // ==========================================================
  // Port state
  typedef struct packed {
    logic [DATA_W-1:0] data_out;
    logic data_oe;
    logic rxf_n;
    logic rxf_oe;
    logic txe_n;
    logic txe_oe;
    logic rd_had_byte;
    logic rx_hold;
    logic send_now;
    logic resume_req;
  } port_state_s;

  localparam port_state_s STATE_RESET = '{
    data_out: DATA_RESET,
    data_oe: DRIVE_OFF,
    rxf_n: FLAG_INACTIVE,
    rxf_oe: DRIVE_OFF,
    txe_n: FLAG_INACTIVE,
    txe_oe: DRIVE_OFF,
    rd_had_byte: 1'h0,
    rx_hold: 1'h0,
    send_now: 1'h0,
    resume_req: 1'h0
  };

  port_state_s st;
  port_state_s next_st;

  // ==========================================================
  // Receive and transmit FIFOs
  logic rx_head_valid;
  logic [DATA_W-1:0] rx_head_data;
  logic rx_pop;
  logic tx_in_ready;
  logic tx_push;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wake_fall;

  assign rd_fall = mode_enable_i && strobe_fell[STROBE_READ];
  assign rd_rise = mode_enable_i && strobe_rose[STROBE_READ];
  assign wr_fall = mode_enable_i && strobe_fell[STROBE_WRITE];
  assign wake_fall = mode_enable_i && strobe_fell[STROBE_WAKE];

  // Pop only a byte that was really shown; a refused read pops nothing
  assign rx_pop = rd_rise && st.rd_had_byte;
  // A write with no room is dropped; the partner must watch the flag
  assign tx_push = wr_fall && tx_in_ready;

  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(usb_rx_valid_i),
    .in_ready_o(usb_rx_ready_o),
    .in_data_i(usb_rx_data_i),
    .out_valid_o(rx_head_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_head_data)
  );

  byte_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_tx_fifo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_ready),
    .in_data_i(chan_data_bus_i),
    .out_valid_o(usb_tx_valid_o),
    .out_ready_i(usb_tx_ready_i),
    .out_data_o(usb_tx_data_o)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.send_now = 1'b0;
    next_st.resume_req = 1'b0;
    next_st.rx_hold = 1'b0;
    // Flags are driven whenever out of reset and the mode is selected
    next_st.rxf_oe = mode_enable_i;
    next_st.txe_oe = mode_enable_i;
    // Bus turns to output only for the length of the read strobe
    next_st.data_oe = mode_enable_i && !read_strobe_n_i;
    if (rd_fall) begin
      next_st.rd_had_byte = rx_head_valid;
      if (rx_head_valid) begin
        next_st.data_out = rx_head_data;
      end
    end
    if (rd_rise) begin
      next_st.rd_had_byte = 1'b0;
    end
    // Hold the flag high one extra cycle so the popped head can settle
    if (rd_rise) begin
      next_st.rxf_n = FLAG_INACTIVE;
      next_st.rx_hold = 1'b1;
    end else if (st.rx_hold || !mode_enable_i) begin
      next_st.rxf_n = FLAG_INACTIVE;
    end else if (read_strobe_n_i) begin
      next_st.rxf_n = !rx_head_valid;
    end
    // A push may fill the last slot, so raise the flag at once
    if (tx_push || !mode_enable_i) begin
      next_st.txe_n = FLAG_INACTIVE;
    end else begin
      next_st.txe_n = !tx_in_ready;
    end
    if (wake_fall) begin
      if (!usb_configured_n_i) begin
        next_st.send_now = 1'b1;
      end else if (remote_wakeup_enable_i) begin
        next_st.resume_req = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  assign chan_data_bus_o = st.data_out;
  assign chan_data_bus_oe_o = st.data_oe;
  assign rx_data_available_n_o = st.rxf_n;
  assign rx_data_available_n_oe_o = st.rxf_oe;
  assign tx_space_available_n_o = st.txe_n;
  assign tx_space_available_n_oe_o = st.txe_oe;
  assign send_now_o = st.send_now;
  assign resume_request_o = st.resume_req;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_read_start;
    mode_enable_i && $fell(read_strobe_n_i) && rx_head_valid;
  endsequence

  sequence s_read_end;
    mode_enable_i && !read_strobe_n_i ##1 mode_enable_i && read_strobe_n_i;
  endsequence

  sequence s_wake_strobe;
    mode_enable_i && send_now_wakeup_n_i ##1 mode_enable_i && !send_now_wakeup_n_i;
  endsequence

  property p_mode_gate;
    !mode_enable_i |=> !chan_data_bus_oe_o && !rx_data_available_n_oe_o
      && !tx_space_available_n_oe_o && !send_now_o && !resume_request_o;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("port active while mode not selected");

  property p_push_on_fall_only;
    tx_push |-> $past(write_strobe_n_i) && !write_strobe_n_i;
  endproperty
  a_push_on_fall_only: assert property (p_push_on_fall_only)
    else $error("transmit push without write strobe fall");

  property p_bus_drive;
    chan_data_bus_oe_o |-> !$past(read_strobe_n_i);
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("data bus driven without read strobe");

  property p_rxf_low;
    !rx_data_available_n_o |-> rx_head_valid;
  endproperty
  a_rxf_low: assert property (p_rxf_low)
    else $error("data-available low with receive FIFO empty");

  property p_rxf_after_read;
    s_read_end |=> rx_data_available_n_o [*2];
  endproperty
  a_rxf_after_read: assert property (p_rxf_after_read)
    else $error("data-available not high after read strobe rose");

  property p_rxf_reset;
    @(posedge clock_i) disable iff (1'b0) !reset_n_i |-> !rx_data_available_n_oe_o;
  endproperty
  a_rxf_reset: assert property (p_rxf_reset)
    else $error("data-available driven during reset");

  property p_txe_low;
    !tx_space_available_n_o |-> tx_in_ready;
  endproperty
  a_txe_low: assert property (p_txe_low)
    else $error("space-available low with transmit FIFO full");

  property p_txe_reset;
    @(posedge clock_i) disable iff (1'b0) !reset_n_i |-> !tx_space_available_n_oe_o;
  endproperty
  a_txe_reset: assert property (p_txe_reset)
    else $error("space-available driven during reset");

  property p_head_on_bus;
    s_read_start |=> chan_data_bus_oe_o && (chan_data_bus_o == $past(rx_head_data));
  endproperty
  a_head_on_bus: assert property (p_head_on_bus)
    else $error("head byte not placed on bus at read strobe fall");

  property p_pop_on_rise;
    s_read_start ##1 (!read_strobe_n_i) [*1] ##1 mode_enable_i && read_strobe_n_i
      |-> rx_pop;
  endproperty
  a_pop_on_rise: assert property (p_pop_on_rise)
    else $error("receive FIFO not popped at read strobe rise");

  property p_capture;
    mode_enable_i && $fell(write_strobe_n_i) && tx_in_ready |-> tx_push;
  endproperty
  a_capture: assert property (p_capture)
    else $error("write strobe fall with room did not capture");

  property p_resume;
    s_wake_strobe ##0 (usb_configured_n_i && remote_wakeup_enable_i)
      |=> resume_request_o && !send_now_o ##1 !resume_request_o;
  endproperty
  a_resume: assert property (p_resume)
    else $error("wake strobe in suspend did not request resume");

  property p_send_now;
    s_wake_strobe ##0 !usb_configured_n_i
      |=> send_now_o && !resume_request_o ##1 !send_now_o;
  endproperty
  a_send_now: assert property (p_send_now)
    else $error("wake strobe while configured did not flush");

endmodule
`default_nettype wire

//--- core/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: DEPTH must be a power of two, at least 2.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo
  import fifo_port_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_fifo DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("byte_fifo WIDTH must be positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } fifo_state_s;

  fifo_state_s st;
  fifo_state_s next_st;
  logic push;
  logic pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o = (st.count != (PTR_W + 1)'(DEPTH));
  assign out_valid_o = (st.count != '0);
  assign out_data_o = st.mem[st.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data_i;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

//--- core/fifo_port_pkg.sv
// Purpose: Shared constants for the asynchronous byte FIFO port.
// Assumes: One 40 MHz clock; strobe pins already synchronous to it.
// Notes: Constants only; no logic.
package fifo_port_pkg;

  // ==========================================================
  // Clock and widths
  localparam int CLOCK_HZ = 40_000_000;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;

  // ==========================================================
  // Strobe inputs, one edge detector each
  localparam int STROBE_COUNT = 3;
  localparam int STROBE_READ = 0;
  localparam int STROBE_WRITE = 1;
  localparam int STROBE_WAKE = 2;
  localparam logic [STROBE_COUNT-1:0] STROBE_IDLE = 3'h7;

  // ==========================================================
  // Reset values of the pins
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic FLAG_INACTIVE = 1'h1;
  localparam logic DRIVE_OFF = 1'h0;
  localparam logic DRIVE_ON = 1'h1;

endpackage

//--- core/strobe_edge.sv
// Purpose: Falling and rising edge detect on one synchronous strobe.
// Assumes: Strobe is idle high and already synchronous to clock_i.
// Notes: Edges are reported in the cycle the new level is sampled.
`timescale 1ns/1ps
`default_nettype none
module strobe_edge (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Strobe level and its edges
  input wire logic strobe_n_i,
  output logic fell_o,
  output logic rose_o
);

  typedef struct packed {
    logic last;
  } edge_state_s;

  edge_state_s st;
  edge_state_s next_st;

  assign fell_o = st.last && !strobe_n_i;
  assign rose_o = !st.last && strobe_n_i;

  always_comb begin
    next_st = st;
    next_st.last = strobe_n_i;
  end

  // Idle high at reset, so a strobe held low across reset counts once
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '{last: 1'h1};
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire
